// file: logic/usb_ep_regs.svh
/*
   Register indices, field positions, mode codes and reset values of the
   endpoint control block.
   Assumes inclusion by its bare name from any file that needs them.
*/
`ifndef USB_EP_REGS_SVH
`define USB_EP_REGS_SVH

// Register indices; byte address on the bus is four times the index
`define REG_ADDR_IDX 8'h10
`define REG_CNT0_IDX 8'h11
`define REG_MODE0_IDX 8'h12
`define REG_CNT1_IDX 8'h13
`define REG_MODE1_IDX 8'h14
`define BUF_FIRST_IDX 8'hF8
`define AXI_AW 10

// Field positions
`define ADDR_EN_BIT 7
`define M_SETUP_BIT 7
`define M_IN_BIT 6
`define M_OUT_BIT 5
`define M_ACK_BIT 4
`define STALL_BIT 7
`define REG_RESET 8'h00

// Endpoint mode codes
`define MODE_DISABLE 4'h0
`define MODE_NAK_INOUT 4'h1
`define MODE_STATUS_OUT 4'h2
`define MODE_STALL_INOUT 4'h3
`define MODE_IGN_INOUT 4'h4
`define MODE_RSV_OUT 4'h5
`define MODE_STATUS_IN 4'h6
`define MODE_RSV_IN 4'h7
`define MODE_NAK_OUT 4'h8
`define MODE_ACK_OUT 4'h9
`define MODE_NAKOUT_STIN 4'hA
`define MODE_ACKOUT_NAKIN 4'hB
`define MODE_NAK_IN 4'hC
`define MODE_ACK_IN 4'hD
`define MODE_NAKIN_STOUT 4'hE
`define MODE_ACKIN_STOUT 4'hF

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: logic/usb_sie_pkg.sv
/*
   Types shared by the endpoint control block and its bench.
   Assumes a decoded token and packet stream on the same clock.
*/
`default_nettype none
package usb_sie_pkg;
   typedef enum logic [1:0] {
      PID_SETUP = 2'h0, PID_IN = 2'h1, PID_OUT = 2'h2, PID_NONE = 2'h3
   } pid_t;
   typedef enum logic [2:0] {
      HS_ACK = 3'h0, HS_NAK = 3'h1, HS_STALL = 3'h2, HS_DATA = 3'h3
   } hs_t;
   typedef enum logic [2:0] {
      A_IGN = 3'h0, A_ACK = 3'h1, A_NAK = 3'h2, A_STALL = 3'h3,
      A_TXCNT = 3'h4, A_TX0 = 3'h5, A_CHECK = 3'h6
   } act_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'h1, S_DATA = 3'h2, S_HOST = 3'h4
   } state_t;
   typedef struct packed {
      logic valid;
      pid_t pid;
      logic [6:0] addr;
      logic ep;
   } token_t;
   typedef struct packed {
      logic valid;
      logic crc_ok;
      logic toggle;
      logic [3:0] len;
   } rx_data_t;
   typedef struct packed {
      logic valid;
      hs_t kind;
      logic [3:0] count;
   } resp_t;
endpackage
`default_nettype wire

// file: logic/usb_endpoint_mode_sie.sv
/*
   Endpoint mode engine with its registers and the control endpoint buffer,
   reached over AXI4-Lite.
   Assumes a packet decoder on CLK that delivers tokens, data packet ends
   and host handshakes as one-cycle strobes; bus reset arrives as a pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_regs.svh"

// Notes on behaviour
// - Address register: 7-bit address plus enable
// - Hardware and bus reset clear the address
// - No answer until address enable is set
// - Control endpoint uses 8-byte buffer F8-FF
// - Endpoint 0 engine update locks its mode writes until read
// - Unlocked mode write clears bits 7 to 4
// - Setup flag forced from data to ACK
// - Mode 0000 ignores everything; reset default
// - SETUP is ACKed in modes 0001-0100, 0110, 1010, 1011, 1110 and 1111, then mode becomes 0001
// - Mode 1011 ACKs OUT, then becomes 0001
// - Mode 1001 ACKs OUT, then becomes 1000
// - Mode 1101 sends count, then becomes 1100
// - Mode 1111 sends count, then becomes 1110
// - Check OUT: ACK only zero length DATA1
// - Send-count answers IN with count field
// - Status IN sends zero length; ignore silent
// - Stall bit turns 1001 and 1101 to STALL
module usb_endpoint_mode_sie (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic USB_BUS_RESET,
   input wire usb_sie_pkg::token_t TOKEN,
   input wire usb_sie_pkg::rx_data_t RX_DATA,
   input wire logic RX_BYTE_VALID,
   input wire logic [7:0] RX_BYTE,
   input wire logic HOST_ACK,
   input wire logic LINK_ABORT,
   input wire logic [2:0] TX_INDEX,
   output var usb_sie_pkg::resp_t RESP,
   output var logic [7:0] TX_BYTE,
   input wire logic [`AXI_AW-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [`AXI_AW-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   import usb_sie_pkg::*;

   // ************************************************************
   // Functions
   // ************************************************************

   // Answer that a mode gives to a token
   function automatic act_t decode(input logic [3:0] m, input pid_t p,
                                   input logic stall);
      act_t a;
      a = A_IGN;
      case (p)
         PID_SETUP:
            case (m)
               `MODE_NAK_INOUT, `MODE_STATUS_OUT, `MODE_STALL_INOUT,
               `MODE_IGN_INOUT, `MODE_STATUS_IN, `MODE_NAKOUT_STIN,
               `MODE_ACKOUT_NAKIN, `MODE_NAKIN_STOUT,
               `MODE_ACKIN_STOUT: a = A_ACK;
               default: a = A_IGN;
            endcase
         PID_IN:
            case (m)
               `MODE_NAK_INOUT, `MODE_ACKOUT_NAKIN, `MODE_NAK_IN,
               `MODE_NAKIN_STOUT: a = A_NAK;
               `MODE_STATUS_OUT, `MODE_STALL_INOUT: a = A_STALL;
               `MODE_STATUS_IN, `MODE_NAKOUT_STIN: a = A_TX0;
               `MODE_RSV_IN, `MODE_ACKIN_STOUT: a = A_TXCNT;
               `MODE_ACK_IN: a = stall ? A_STALL : A_TXCNT;
               default: a = A_IGN;
            endcase
         PID_OUT:
            case (m)
               `MODE_NAK_INOUT, `MODE_NAK_OUT,
               `MODE_NAKOUT_STIN: a = A_NAK;
               `MODE_STALL_INOUT, `MODE_STATUS_IN: a = A_STALL;
               `MODE_STATUS_OUT, `MODE_NAKIN_STOUT,
               `MODE_ACKIN_STOUT: a = A_CHECK;
               `MODE_RSV_OUT, `MODE_ACKOUT_NAKIN: a = A_ACK;
               `MODE_ACK_OUT: a = stall ? A_STALL : A_ACK;
               default: a = A_IGN;
            endcase
         default: a = A_IGN;
      endcase
      return a;
   endfunction

   // Mode that the engine leaves behind after an ACK
   function automatic logic [3:0] after_ack(input logic [3:0] m,
                                            input pid_t p);
      logic [3:0] n;
      n = m;
      if (p == PID_SETUP)
         n = `MODE_NAK_INOUT;
      else
         case (m)
            `MODE_ACKOUT_NAKIN: n = `MODE_NAK_INOUT;
            `MODE_ACK_OUT: n = `MODE_NAK_OUT;
            `MODE_ACK_IN: n = `MODE_NAK_IN;
            `MODE_ACKIN_STOUT: n = `MODE_NAKIN_STOUT;
            default: n = m;
         endcase
      return n;
   endfunction

   // Whether a register index answers on the bus
   function automatic logic mapped(input logic [7:0] idx);
      return (idx >= `REG_ADDR_IDX && idx <= `REG_MODE1_IDX) ||
             idx >= `BUF_FIRST_IDX;
   endfunction

   // ************************************************************
   // State
   // ************************************************************

   state_t st_q, st_d;
   act_t act_q, act_d, tok_act;
   pid_t pid_q, pid_d;
   logic ep_q, ep_d, lock_q, lock_d, force_q, force_d, hw_upd, hit, ack;
   logic brs1_q, brs2_q;
   logic [7:0] addr_q, addr_d, m0_q, m0_d, c0_q, c0_d, m1_q, m1_d;
   logic [7:0] c1_q, c1_d, rd_val, cnt;
   logic [2:0] rxp_q, rxp_d;
   logic [7:0] buf_q [8];
   logic [7:0] buf_d [8];
   resp_t resp_q, resp_d;
   logic [7:0] tx_q;
   logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
   logic [`AXI_AW-1:0] awa_q, awa_d;
   logic [7:0] wd_q, wd_d;
   logic ws_q, ws_d, wr_go, wr_en, rd_m0;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;

   assign RESP = resp_q;
   assign TX_BYTE = tx_q;
   assign AWREADY = awready_q;
   assign WREADY = wready_q;
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;
   assign ARREADY = arready_q;
   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;

   // ************************************************************
   // Register bus
   // ************************************************************

   // Commit a write once both halves are held; one at a time
   assign wr_go = aw_q && w_q && !bvalid_q;
   assign wr_en = wr_go && ws_q;
   assign rd_m0 = ARVALID && arready_q &&
                  ARADDR[`AXI_AW-1:2] == `REG_MODE0_IDX;

   // Read data mux over the registers and buffer
   always_comb begin
      case (ARADDR[`AXI_AW-1:2])
         `REG_ADDR_IDX: rd_val = addr_q;
         `REG_CNT0_IDX: rd_val = c0_q;
         `REG_MODE0_IDX: rd_val = m0_q;
         `REG_CNT1_IDX: rd_val = c1_q;
         `REG_MODE1_IDX: rd_val = m1_q;
         default: rd_val = mapped(ARADDR[`AXI_AW-1:2]) ?
                           buf_q[ARADDR[4:2]] : `REG_RESET;
      endcase
   end

   // Channel handshakes; ready drops while a half or an answer is held
   always_comb begin
      aw_d = aw_q;
      awa_d = awa_q;
      w_d = w_q;
      wd_d = wd_q;
      ws_d = ws_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (AWVALID && awready_q)
      begin
         aw_d = 1'b1;
         awa_d = AWADDR;
      end
      if (WVALID && wready_q)
      begin
         w_d = 1'b1;
         wd_d = WDATA[7:0];
         ws_d = WSTRB[0];
      end
      if (wr_go)
      begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = mapped(awa_q[`AXI_AW-1:2]) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_q && BREADY)
         bvalid_d = 1'b0;
      if (ARVALID && arready_q)
      begin
         rvalid_d = 1'b1;
         rdata_d = {24'h0, rd_val};
         rresp_d = mapped(ARADDR[`AXI_AW-1:2]) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_q && RREADY)
         rvalid_d = 1'b0;
      awready_d = !aw_d && !bvalid_d;
      wready_d = !w_d && !bvalid_d;
      arready_d = !rvalid_d;
   end

   // Bus state registers
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST)
      begin
         aw_q <= 1'b0;
         awa_q <= '0;
         w_q <= 1'b0;
         wd_q <= `REG_RESET;
         ws_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `RESP_OKAY;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         arready_q <= 1'b1;
      end
      else
      begin
         aw_q <= aw_d;
         awa_q <= awa_d;
         w_q <= w_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         arready_q <= arready_d;
      end
   end

   // ************************************************************
   // Endpoint engine
   // ************************************************************

   // Token is ours only with the address enabled and matching
   assign hit = addr_q[`ADDR_EN_BIT] && TOKEN.addr == addr_q[6:0];
   assign tok_act = decode(TOKEN.ep ? m1_q[3:0] : m0_q[3:0], TOKEN.pid,
                           TOKEN.ep & m1_q[`STALL_BIT]);
   assign ack = act_q == A_ACK || (act_q == A_CHECK &&
                RX_DATA.len == 4'h0 && RX_DATA.toggle);
   assign cnt = {RX_DATA.toggle, 3'h4, RX_DATA.len};

   // Firmware writes are applied first so engine updates override them
   always_comb begin
      st_d = st_q;
      act_d = act_q;
      ep_d = ep_q;
      pid_d = pid_q;
      addr_d = addr_q;
      m0_d = m0_q;
      c0_d = c0_q;
      m1_d = m1_q;
      c1_d = c1_q;
      force_d = force_q;
      rxp_d = rxp_q;
      buf_d = buf_q;
      resp_d = '0;
      hw_upd = 1'b0;
      if (wr_en)
         case (awa_q[`AXI_AW-1:2])
            `REG_ADDR_IDX: addr_d = wd_q;
            `REG_CNT0_IDX: c0_d = wd_q;
            `REG_CNT1_IDX: c1_d = wd_q;
            `REG_MODE1_IDX: m1_d = {wd_q[7], 3'h0, wd_q[3:0]};
            `REG_MODE0_IDX: if (!lock_q) m0_d = {force_q, 3'h0, wd_q[3:0]};
            default: if (mapped(awa_q[`AXI_AW-1:2])) buf_d[awa_q[4:2]] = wd_q;
         endcase
      case (st_q)
         S_IDLE:
            if (TOKEN.valid && hit && tok_act != A_IGN)
            begin
               ep_d = TOKEN.ep;
               pid_d = TOKEN.pid;
               act_d = tok_act;
               if (TOKEN.pid == PID_IN)
               begin
                  resp_d.valid = 1'b1;
                  resp_d.kind = tok_act == A_NAK ? HS_NAK :
                                tok_act == A_STALL ? HS_STALL : HS_DATA;
                  if (tok_act == A_TXCNT)
                     resp_d.count = TOKEN.ep ? c1_q[3:0] : c0_q[3:0];
                  if (tok_act == A_TXCNT || tok_act == A_TX0)
                     st_d = S_HOST;
                  if (!TOKEN.ep)
                  begin
                     m0_d[`M_IN_BIT] = 1'b1;
                     hw_upd = 1'b1;
                  end
               end
               else
               begin
                  st_d = S_DATA;
                  rxp_d = 3'h0;
                  if (!TOKEN.ep)
                  begin
                     hw_upd = 1'b1;
                     if (TOKEN.pid == PID_SETUP)
                     begin
                        force_d = 1'b1;
                        m0_d[`M_SETUP_BIT] = 1'b1;
                     end
                     else
                        m0_d[`M_OUT_BIT] = 1'b1;
                  end
               end
            end
         S_DATA:
         begin
            // Control endpoint data lands in the shared buffer
            if (RX_BYTE_VALID && !ep_q)
            begin
               buf_d[rxp_q] = RX_BYTE;
               rxp_d = rxp_q + 3'h1;
            end
            if (LINK_ABORT || RX_DATA.valid)
            begin
               st_d = S_IDLE;
               force_d = 1'b0;
            end
            // A corrupt packet gets no handshake at all
            if (!LINK_ABORT && RX_DATA.valid && RX_DATA.crc_ok)
            begin
               resp_d.valid = 1'b1;
               resp_d.kind = ack ? HS_ACK :
                             act_q == A_NAK ? HS_NAK : HS_STALL;
               if (ack && ep_q)
               begin
                  c1_d = cnt;
                  m1_d[`M_ACK_BIT] = 1'b1;
                  m1_d[3:0] = after_ack(m1_q[3:0], pid_q);
               end
               else if (ack)
               begin
                  c0_d = cnt;
                  m0_d[`M_ACK_BIT] = 1'b1;
                  m0_d[3:0] = after_ack(m0_q[3:0], pid_q);
                  hw_upd = 1'b1;
               end
            end
         end
         S_HOST:
            if (HOST_ACK)
            begin
               st_d = S_IDLE;
               if (ep_q)
               begin
                  m1_d[`M_ACK_BIT] = 1'b1;
                  m1_d[3:0] = after_ack(m1_q[3:0], pid_q);
               end
               else
               begin
                  m0_d[`M_ACK_BIT] = 1'b1;
                  m0_d[3:0] = after_ack(m0_q[3:0], pid_q);
                  hw_upd = 1'b1;
               end
            end
            else if (LINK_ABORT || TOKEN.valid)
               st_d = S_IDLE;
         default: st_d = S_IDLE;
      endcase
      // Lock: an engine update in the same cycle as the read wins
      lock_d = hw_upd ? 1'b1 : (rd_m0 ? 1'b0 : lock_q);
      if (brs2_q)
      begin
         st_d = S_IDLE;
         addr_d = `REG_RESET;
         m0_d = `REG_RESET;
         m1_d = `REG_RESET;
         c0_d = `REG_RESET;
         c1_d = `REG_RESET;
         force_d = 1'b0;
         lock_d = 1'b0;
         resp_d = '0;
      end
   end

   // Engine and register state; bus reset pin passes two flops first
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST)
      begin
         brs1_q <= 1'b0;
         brs2_q <= 1'b0;
         st_q <= S_IDLE;
         act_q <= A_IGN;
         ep_q <= 1'b0;
         pid_q <= PID_NONE;
         addr_q <= `REG_RESET;
         m0_q <= `REG_RESET;
         c0_q <= `REG_RESET;
         m1_q <= `REG_RESET;
         c1_q <= `REG_RESET;
         lock_q <= 1'b0;
         force_q <= 1'b0;
         rxp_q <= 3'h0;
         resp_q <= '0;
         tx_q <= `REG_RESET;
         for (int i = 0; i < 8; i++)
            buf_q[i] <= `REG_RESET;
      end
      else
      begin
         brs1_q <= USB_BUS_RESET;
         brs2_q <= brs1_q;
         st_q <= st_d;
         act_q <= act_d;
         ep_q <= ep_d;
         pid_q <= pid_d;
         addr_q <= addr_d;
         m0_q <= m0_d;
         c0_q <= c0_d;
         m1_q <= m1_d;
         c1_q <= c1_d;
         lock_q <= lock_d;
         force_q <= force_d;
         rxp_q <= rxp_d;
         resp_q <= resp_d;
         tx_q <= buf_q[TX_INDEX];
         buf_q <= buf_d;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   sequence data_ok_s;
      st_q == S_DATA && RX_DATA.valid && RX_DATA.crc_ok && !LINK_ABORT &&
      !brs2_q;
   endsequence

   addr_clear_a: assert property (brs2_q |=> addr_q == 8'h00)
      else $error("bus reset left address set");
   addr_gate_a: assert property (
      st_q == S_IDLE && !addr_q[7] |=> !resp_q.valid)
      else $error("answer with address disabled");
   lock_hold_a: assert property (
      lock_q && wr_en && !hw_upd && !brs2_q &&
      awa_q[`AXI_AW-1:2] == `REG_MODE0_IDX |=> $stable(m0_q))
      else $error("locked mode register changed");
   write_clear_a: assert property (
      !lock_q && wr_en && !hw_upd && !brs2_q && !force_q &&
      awa_q[`AXI_AW-1:2] == `REG_MODE0_IDX |=> m0_q[7:4] == 4'h0)
      else $error("unlocked write kept flag bits");
   setup_force_a: assert property (force_q |-> m0_q[7])
      else $error("setup flag low during setup");
   setup_nak_a: assert property (
      data_ok_s and pid_q == PID_SETUP && !ep_q |=>
      resp_q.valid && resp_q.kind == HS_ACK && m0_q[3:0] == 4'h1)
      else $error("setup not ACKed into NAK mode");
   out_back_a: assert property (
      data_ok_s and !ep_q && act_q == A_ACK && pid_q == PID_OUT &&
      m0_q[3:0] == 4'hB |=> m0_q[3:0] == 4'h1)
      else $error("mode 1011 not back to 0001");
   check_out_a: assert property (
      data_ok_s and act_q == A_CHECK &&
      (RX_DATA.len != 4'h0 || !RX_DATA.toggle) |=>
      resp_q.valid && resp_q.kind == HS_STALL)
      else $error("bad status OUT was ACKed");
   in_count_a: assert property (
      st_q == S_IDLE && TOKEN.valid && hit &&
      tok_act == A_TXCNT && !TOKEN.ep && !brs2_q |=>
      resp_q.valid && resp_q.count == $past(c0_q[3:0]) && st_q == S_HOST)
      else $error("IN count differs from register");
endmodule // usb_endpoint_mode_sie
`default_nettype wire

// file: test/usb_host_model.sv
/*
   Host side model: sends tokens and data packets, acknowledges IN data.
   Assumes the engine answers on RESP one cycle after each packet.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
   input wire logic CLK,
   input wire usb_sie_pkg::resp_t RESP,
   output var usb_sie_pkg::token_t TOKEN,
   output var usb_sie_pkg::rx_data_t RX_DATA,
   output var logic RX_BYTE_VALID,
   output var logic [7:0] RX_BYTE,
   output var logic HOST_ACK
);
   import usb_sie_pkg::*;
   int n_resp = 0;
   resp_t got;

   // Quiet bus at time zero
   initial
   begin
      TOKEN = '0;
      RX_DATA = '0;
      RX_BYTE_VALID = 1'b0;
      RX_BYTE = 8'h00;
      HOST_ACK = 1'b0;
   end

   //****************************************
   // Transactions
   //****************************************
   // SETUP carries 8 bytes, OUT carries out_n; e picks the endpoint
   task automatic send(input pid_t p, input logic [6:0] a,
                       input logic [3:0] out_n, input logic e);
      int i;
      logic [3:0] n;
      n = (p == PID_SETUP) ? 4'h8 : out_n;
      @(posedge CLK);
      TOKEN <= '{1'b1, p, a, e}; // One-cycle token to endpoint e, SETUP included
      @(posedge CLK);
      TOKEN <= '{1'b0, PID_NONE, ~a, 1'b1}; // No stale token when idle
      if (p != PID_IN)
      begin
         for (i = 0; i < n; i++)
         begin
            RX_BYTE_VALID <= 1'b1;
            RX_BYTE <= 8'hC0 + 8'(i);
            @(posedge CLK);
         end
         RX_BYTE_VALID <= 1'b0;
         RX_BYTE <= ~RX_BYTE;
         RX_DATA <= '{1'b1, 1'b1, p == PID_OUT, n}; // Status OUT is DATA1
         @(posedge CLK);
         RX_DATA <= '{1'b0, 1'b0, ~RX_DATA.toggle, ~n};
      end
   endtask

   // Count answers; every data packet is acknowledged promptly
   always @(posedge CLK)
   begin
      HOST_ACK <= RESP.valid && RESP.kind == HS_DATA;
      if (RESP.valid)
      begin
         got <= RESP;
         n_resp <= n_resp + 1;
      end
   end
endmodule // usb_host_model
`default_nettype wire

// file: test/usb_endpoint_mode_sie_tb.sv
/*
   Bench for the endpoint mode engine: reset, then answer table, mode
   change, buffer, lock and bus reset cases.
   Assumes the host model drives the link side.
*/
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_regs.svh"
module usb_endpoint_mode_sie_tb;
   import usb_sie_pkg::*;
   logic clk = 0, rst = 1, bus_rst = 0;
   logic [`AXI_AW-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = '0, rdata;
   logic awready, wready, bvalid, arready, rvalid, rx_byte_valid, host_ack;
   logic [1:0] bresp, rresp, rr;
   logic [2:0] tx_index = '0;
   logic [7:0] tx_byte, rx_byte, rd;
   logic [6:0] dev = 7'h2A;
   logic [15:0] r;
   logic ok;
   token_t token;
   rx_data_t rx_data;
   resp_t resp;
   int n_errors = 0, compares = 0, base;
   // Mode, token, answer (F none), count
   logic [15:0] rows [22] = '{16'h01F0, 16'h1000, 16'h1110, 16'h1210,
      16'h2120, 16'h2200, 16'h3220, 16'h41F0, 16'h6130, 16'h6220, 16'h8210,
      16'h80F0, 16'h9200, 16'hA130, 16'hB110, 16'hB200, 16'hC110, 16'hD135,
      16'hD2F0, 16'hE110, 16'hE000, 16'hF135};
   // Mode, token, mode after the engine update
   logic [11:0] steps [5] = '{12'hB21, 12'h928, 12'hD1C, 12'hF1E, 12'hF01};

   always #2.5 clk = ~clk;

   usb_endpoint_mode_sie u_usb_endpoint_mode_sie (.CLK(clk), .SYS_RST(rst),
      .USB_BUS_RESET(bus_rst), .TOKEN(token), .RX_DATA(rx_data),
      .RX_BYTE_VALID(rx_byte_valid), .RX_BYTE(rx_byte), .HOST_ACK(host_ack),
      .LINK_ABORT(1'b0), .TX_INDEX(tx_index), .RESP(resp), .TX_BYTE(tx_byte),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
      .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
      .RREADY(rready));

   usb_host_model u_usb_host_model (.CLK(clk), .RESP(resp), .TOKEN(token),
      .RX_DATA(rx_data), .RX_BYTE_VALID(rx_byte_valid), .RX_BYTE(rx_byte),
      .HOST_ACK(host_ack));

   //****************************************
   // Shared tasks
   //****************************************
   task automatic chk(input logic good, input string m);
      compares++;
      if (!good)
      begin
         n_errors++;
         $display("unexpected at %0t ns: %s", $time, m);
      end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Write: both halves offered together, each dropped once taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic aw, w;
      aw = 0;
      w = 0;
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, v};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         aw |= awready;
         w |= wready;
      end while (!(aw && w));
      do @(posedge clk); while (!bvalid);
      rr = bresp;
      bready <= 0;
   endtask

   task automatic rdr(input logic [7:0] idx, output logic [7:0] v,
                      output logic [1:0] resp_code);
      @(posedge clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1;
      rready <= 1;
      do @(posedge clk); while (!arready);
      arvalid <= 0;
      do @(posedge clk); while (!rvalid);
      v = rdata[7:0];
      resp_code = rresp;
      rready <= 0;
   endtask

   // Unlock by reading, set mode and a count of 5, then one transaction
   task automatic xfer(input logic [3:0] m, input pid_t p,
                       input logic [3:0] n);
      rdr(`REG_MODE0_IDX, rd, rr);
      wr(`REG_MODE0_IDX, {4'h0, m});
      wr(`REG_CNT0_IDX, 8'h05);
      base = u_usb_host_model.n_resp;
      u_usb_host_model.send(p, dev, n, 1'b0);
      repeat (4) @(posedge clk);
   endtask

   //****************************************
   // Tests
   //****************************************
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 0;
      rdr(`REG_ADDR_IDX, rd, rr);
      chk(rd === 8'h00, "address not clear");
      rdr(`REG_MODE0_IDX, rd, rr);
      chk(rd === 8'h00, "mode not disabled");
      // USB operation only: pin forcing codes are never selected
      wr(`REG_ADDR_IDX, {1'b1, dev});
      rdr(`REG_ADDR_IDX, rd, rr);
      chk(rd === {1'b1, dev}, "address readback");
      $display("test reset done");
      foreach (rows[i])
      begin
         r = rows[i];
         xfer(r[15:12], pid_t'(r[9:8]), 4'h0);
         ok = u_usb_host_model.n_resp == base + 1 &&
            u_usb_host_model.got.kind === hs_t'(r[6:4]) &&
            (r[6:4] != 3'h3 || u_usb_host_model.got.count === r[3:0]);
         if (r[7:4] == 4'hF) ok = u_usb_host_model.n_resp == base;
         chk(ok, "wrong answer");
      end
      $display("test table done");
      foreach (steps[i])
      begin
         xfer(steps[i][11:8], pid_t'(steps[i][5:4]), 4'h0);
         rdr(`REG_MODE0_IDX, rd, rr);
         chk(rd[3:0] === steps[i][3:0], "mode after");
      end
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         tx_index <= i[2:0];
         repeat (2) @(posedge clk);
         chk(tx_byte === 8'hC0 + 8'(i), "buffer byte");
      end
      $display("test mode changes done");
      xfer(4'h1, PID_SETUP, 4'h0);
      wr(`REG_MODE0_IDX, 8'h09);
      rdr(`REG_MODE0_IDX, rd, rr);
      chk(rd[3:0] === 4'h1, "locked write took");
      wr(`REG_MODE0_IDX, 8'hF9);
      rdr(`REG_MODE0_IDX, rd, rr);
      chk(rd === 8'h09, "flags not cleared");
      xfer(4'h2, PID_OUT, 4'h2);
      ok = u_usb_host_model.n_resp == base + 1 &&
         u_usb_host_model.got.kind === HS_STALL;
      chk(ok, "bad status OUT");
      wr(`REG_MODE1_IDX, 8'h89); // Stalled ACK OUT, no SETUP mode
      base = u_usb_host_model.n_resp;
      u_usb_host_model.send(PID_OUT, dev, 4'h0, 1'b1);
      repeat (4) @(posedge clk);
      ok = u_usb_host_model.n_resp == base + 1 &&
         u_usb_host_model.got.kind === HS_STALL;
      chk(ok, "stall bit");
      $display("test lock done");
      wr(`REG_ADDR_IDX, {1'b0, dev});
      xfer(4'h1, PID_IN, 4'h0);
      chk(u_usb_host_model.n_resp == base, "answer while disabled");
      wr(`REG_ADDR_IDX, {1'b1, dev});
      @(posedge clk);
      bus_rst <= 1;
      repeat (6) @(posedge clk);
      bus_rst <= 0;
      rdr(`REG_ADDR_IDX, rd, rr);
      chk(rd === 8'h00, "bus reset address");
      rdr(`REG_MODE0_IDX, rd, rr);
      chk(rd === 8'h00, "bus reset mode");
      rdr(8'h30, rd, rr);
      chk(rr === `RESP_SLVERR, "unmapped read");
      wr(8'h30, 8'h00);
      chk(rr === `RESP_SLVERR, "unmapped write");
      $display("test bus reset done");
      end_of_test;
   end

   // Watchdog well past the expected run length
   initial
   begin
      #50000;
      n_errors++;
      $display("unexpected at %0t ns: timeout", $time);
      end_of_test;
   end
endmodule // usb_endpoint_mode_sie_tb
`default_nettype wire
